// File: inc/bco_pkg.sv
package bco_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CH4_VOLTAGE_CODE = 8'h04;
  localparam logic [7:0] ADDR_RAMP_CONFIG = 8'h05;
  localparam logic [7:0] ADDR_OPTION_CONFIG = 8'h06;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CH4_CODE_LSB = 0;
  localparam int CH4_CODE_W = 5;
  localparam int CH4_RAMP_ENABLE_BIT = 6;
  localparam int CH4_RAMP_INTERVAL_LSB = 4;
  localparam int CH1_RAMP_ENABLE_BIT = 2;
  localparam int CH1_RAMP_INTERVAL_LSB = 0;
  localparam int POWER_SAVE_SELECT_LSB = 0;
  localparam int DISCHARGE_ENABLE_LSB = 4;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [4:0] CH4_CODE_ADJUSTABLE = 5'h00;
  localparam logic [1:0] RST_RAMP_INTERVAL = 2'h0;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 8000;
  localparam int INTERVAL0_PS = 62500000;
  localparam int INTERVAL1_PS = 31200000;
  localparam int INTERVAL2_PS = 15600000;
  localparam int INTERVAL3_PS = 7800000;
  localparam int INTERVAL0_CYC = INTERVAL0_PS / CLK_PERIOD_PS;
  localparam int INTERVAL1_CYC = INTERVAL1_PS / CLK_PERIOD_PS;
  localparam int INTERVAL2_CYC = INTERVAL2_PS / CLK_PERIOD_PS;
  localparam int INTERVAL3_CYC = INTERVAL3_PS / CLK_PERIOD_PS;

  // Serial port device address; the value is arbitrary.
  localparam logic [6:0] DEV_ADDR = 7'h2A;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    SP_IDLE = 5'h01,
    SP_RECV = 5'h02,
    SP_ACK = 5'h04,
    SP_SEND = 5'h08,
    SP_MACK = 5'h10
  } bco_sp_state_t;

  typedef struct packed {
    logic [7:0] ch4_voltage_code;
    logic [7:0] ramp_config;
    logic [7:0] option_config;
  } bco_regs_t;

  typedef struct packed {
    logic loaded;
    bco_regs_t regs;
    logic scl_d;
    logic sda_d;
    bco_sp_state_t sp;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic addr_phase;
    logic ptr_done;
    logic rd;
    logic sda_oe;
    logic [3:0] auto_power_save;
    logic ch4_adjustable;
  } bco_state_t;

endpackage

// File: rtl/bco_sync.sv
`timescale 1ns/1ns
module bco_sync #(
  parameter int W = 1
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta;

  // The first stage feeds only the second stage.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta <= '0;
      o_sync <= '0;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end

endmodule

// File: rtl/bco_ramp_timer.sv
`timescale 1ns/1ns
module bco_ramp_timer #(
  parameter int CYC0 = 7812,
  parameter int CYC1 = 3900,
  parameter int CYC2 = 1950,
  parameter int CYC3 = 975
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_enable,
  input wire logic [1:0] i_interval,
  output logic o_step
);

  localparam int CW = $clog2(CYC0 + 1);

  logic [CW-1:0] cnt;
  logic [CW-1:0] limit;

  if (CYC3 < 1 || CYC2 < CYC3 || CYC1 < CYC2 || CYC0 < CYC1) begin : g_chk
    $error("Ramp intervals must be at least one cycle and in falling order.");
  end

  always_comb begin
    unique case (i_interval)
      2'h0: limit = CW'(CYC0 - 1);
      2'h1: limit = CW'(CYC1 - 1);
      2'h2: limit = CW'(CYC2 - 1);
      2'h3: limit = CW'(CYC3 - 1);
    endcase
  end

  // A shortened interval takes effect at once, since the compare is >=.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt <= '0;
      o_step <= 1'b0;
    end else if (!i_enable) begin
      cnt <= '0;
      o_step <= 1'b0;
    end else if (cnt >= limit) begin
      cnt <= '0;
      o_step <= 1'b1;
    end else begin
      cnt <= cnt + CW'(1);
      o_step <= 1'b0;
    end
  end

endmodule

// File: rtl/bco_option_regs.sv
`timescale 1ns/1ns
// What this block does
// - Decode channel-4 code, zero means adjustable
// - Channel-4 code resets from fuse
// - Bit 6 enables channel-4 ramping, resets off
// - Bits 5:4 pick channel-4 ramp step
// - Bit 2 enables channel-1 ramping, resets off
// - Bits 1:0 pick channel-1 ramp step
// - Mode pin low forces automatic power save
// - Select bits count when pin high or clocked
// - Option bits 3:0 pick forced or automatic
// - Option bits 7:4 enable output discharge
// - All discharge bits reset from one fuse
module bco_option_regs #(
  parameter logic [6:0] P_DEV_ADDR = bco_pkg::DEV_ADDR,
  parameter int P_INTERVAL0_CYC = bco_pkg::INTERVAL0_CYC,
  parameter int P_INTERVAL1_CYC = bco_pkg::INTERVAL1_CYC,
  parameter int P_INTERVAL2_CYC = bco_pkg::INTERVAL2_CYC,
  parameter int P_INTERVAL3_CYC = bco_pkg::INTERVAL3_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire logic i_sync_mode,
  input wire logic i_sync_mode_is_clock,
  input wire logic [4:0] i_fuse_ch4_code,
  input wire logic i_fuse_discharge_enable,
  output logic [4:0] o_ch4_voltage_code,
  output logic o_ch4_adjustable,
  output logic o_ch1_ramp_enable,
  output logic o_ch4_ramp_enable,
  output logic o_ch1_ramp_step,
  output logic o_ch4_ramp_step,
  output logic [3:0] o_auto_power_save,
  output logic [3:0] o_discharge_enable
);

  // ---------------------------------------------------------------
  // Parameter checks
  // ---------------------------------------------------------------
  // Addresses 0000xxx and 1111xxx are set aside on the bus for special use.
  if (P_DEV_ADDR[6:3] == 4'h0 || P_DEV_ADDR[6:3] == 4'hF) begin : g_addr_chk
    $error("Device address must lie outside the reserved ranges.");
  end

  // An interval of one cycle would hold the step high instead of pulsing it.
  if (P_INTERVAL3_CYC < 2) begin : g_step_chk
    $error("The shortest ramp interval must be at least two cycles.");
  end

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // The synchroniser clears to zero, so the pins pass it inverted: after reset the
  // lines then read at their idle high level and no false edge or start follows.
  logic [2:0] pins_n;
  logic scl;
  logic sda;
  logic mode_pin;

  bco_sync #(
    .W(3)
  ) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_async(~{i_sync_mode, i_sda, i_scl}),
    .o_sync(pins_n)
  );

  assign scl = !pins_n[0];
  assign sda = !pins_n[1];
  assign mode_pin = !pins_n[2];

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  bco_pkg::bco_state_t st;
  bco_pkg::bco_state_t next_st;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic [7:0] rx_byte;
  logic [7:0] rd_data;

  function automatic logic [7:0] read_reg(input bco_pkg::bco_regs_t r,
                                          input logic [7:0] a);
    unique case (a)
      bco_pkg::ADDR_CH4_VOLTAGE_CODE: read_reg = r.ch4_voltage_code;
      bco_pkg::ADDR_RAMP_CONFIG: read_reg = r.ramp_config;
      bco_pkg::ADDR_OPTION_CONFIG: read_reg = r.option_config;
      default: read_reg = 8'h00;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Line events and read data
  // ---------------------------------------------------------------
  assign scl_rise = scl && !st.scl_d;
  assign scl_fall = !scl && st.scl_d;
  assign start_cond = scl && st.scl_d && st.sda_d && !sda;
  assign stop_cond = scl && st.scl_d && !st.sda_d && sda;
  assign rx_byte = {st.shift[6:0], sda};
  assign rd_data = read_reg(st.regs, st.ptr);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.scl_d = scl;
    next_st.sda_d = sda;

    // Fuse settings are caught on the first edge after reset release.
    if (!st.loaded) begin
      next_st.loaded = 1'b1;
      next_st.regs.ch4_voltage_code = {3'h0, i_fuse_ch4_code};
      next_st.regs.option_config = {{4{i_fuse_discharge_enable}}, 4'h0};
    end

    // A start or stop on the lines ends whatever byte is in flight.
    if (start_cond) begin
      next_st.sp = bco_pkg::SP_RECV;
      next_st.bit_cnt = 4'h0;
      next_st.addr_phase = 1'b1;
      next_st.ptr_done = 1'b0;
      next_st.sda_oe = 1'b0;
    end else if (stop_cond) begin
      next_st.sp = bco_pkg::SP_IDLE;
      next_st.sda_oe = 1'b0;
    end else begin
      unique case (st.sp)
        bco_pkg::SP_IDLE: begin
          // Nothing is driven between frames.
          next_st.sda_oe = 1'b0;
        end
        bco_pkg::SP_RECV: begin
          if (scl_rise && st.bit_cnt != 4'h8) begin
            next_st.shift = rx_byte;
            next_st.bit_cnt = st.bit_cnt + 4'h1;
          end else if (scl_fall && st.bit_cnt == 4'h8) begin
            next_st.sp = bco_pkg::SP_ACK;
            next_st.sda_oe = 1'b1;
            if (st.addr_phase) begin
              next_st.rd = st.shift[0];
              // A foreign address leaves the line untouched until the next start.
              if (st.shift[7:1] != P_DEV_ADDR) begin
                next_st.sp = bco_pkg::SP_IDLE;
                next_st.sda_oe = 1'b0;
              end
            end else if (!st.ptr_done) begin
              // The pointer outlives the frame, so a read can follow a pointer write.
              next_st.ptr = st.shift;
              next_st.ptr_done = 1'b1;
            end else begin
              unique case (st.ptr)
                bco_pkg::ADDR_CH4_VOLTAGE_CODE: next_st.regs.ch4_voltage_code = st.shift;
                bco_pkg::ADDR_RAMP_CONFIG: next_st.regs.ramp_config = st.shift;
                bco_pkg::ADDR_OPTION_CONFIG: next_st.regs.option_config = st.shift;
                default: begin
                  // Pointers outside the map are acknowledged and dropped.
                end
              endcase
              next_st.ptr = st.ptr + 8'h01;
            end
          end
        end
        bco_pkg::SP_ACK: begin
          if (scl_fall) begin
            next_st.bit_cnt = 4'h0;
            next_st.addr_phase = 1'b0;
            if (st.rd) begin
              // The first bit goes out at this fall, well before the host's next rise.
              next_st.sp = bco_pkg::SP_SEND;
              next_st.shift = rd_data;
              next_st.sda_oe = !rd_data[7];
            end else begin
              next_st.sp = bco_pkg::SP_RECV;
              next_st.sda_oe = 1'b0;
            end
          end
        end
        bco_pkg::SP_SEND: begin
          if (scl_rise) begin
            next_st.bit_cnt = st.bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (st.bit_cnt == 4'h8) begin
              next_st.sp = bco_pkg::SP_MACK;
              next_st.sda_oe = 1'b0;
              next_st.ptr = st.ptr + 8'h01;
            end else begin
              // The next bit goes out while the clock is low.
              next_st.shift = {st.shift[6:0], 1'b0};
              next_st.sda_oe = !st.shift[6];
            end
          end
        end
        bco_pkg::SP_MACK: begin
          // A high acknowledge from the host ends the read burst.
          if (scl_rise && sda) begin
            next_st.sp = bco_pkg::SP_IDLE;
          end else if (scl_fall) begin
            next_st.sp = bco_pkg::SP_SEND;
            next_st.bit_cnt = 4'h0;
            next_st.shift = rd_data;
            next_st.sda_oe = !rd_data[7];
          end
        end
        default: begin
          next_st.sp = bco_pkg::SP_IDLE;
          next_st.sda_oe = 1'b0;
        end
      endcase
    end

    // The mode follows the pin three cycles late, through the synchroniser.
    // Pin low forces automatic, unless the pin is used as a clock
    if (!mode_pin && !i_sync_mode_is_clock) begin
      next_st.auto_power_save = 4'hF;
    end else begin
      next_st.auto_power_save =
        st.regs.option_config[bco_pkg::POWER_SAVE_SELECT_LSB +: 4];
    end
    next_st.ch4_adjustable =
      st.regs.ch4_voltage_code[bco_pkg::CH4_CODE_LSB +: bco_pkg::CH4_CODE_W]
      == bco_pkg::CH4_CODE_ADJUSTABLE;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
      st.sp <= bco_pkg::SP_IDLE;
      // Line history resets high, the idle level of both lines.
      st.scl_d <= 1'b1;
      st.sda_d <= 1'b1;
      st.regs <= '{bco_pkg::RST_REG, bco_pkg::RST_REG, bco_pkg::RST_REG};
      st.ch4_adjustable <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Ramp step timers
  // ---------------------------------------------------------------
  // Both timers share one set of interval counts; only the field differs.
  // Channel-4 ramp
  bco_ramp_timer #(
    .CYC0(P_INTERVAL0_CYC),
    .CYC1(P_INTERVAL1_CYC),
    .CYC2(P_INTERVAL2_CYC),
    .CYC3(P_INTERVAL3_CYC)
  ) u_ch4_ramp (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_enable(st.regs.ramp_config[bco_pkg::CH4_RAMP_ENABLE_BIT]),
    .i_interval(st.regs.ramp_config[bco_pkg::CH4_RAMP_INTERVAL_LSB +: 2]),
    .o_step(o_ch4_ramp_step)
  );

  bco_ramp_timer #(
    .CYC0(P_INTERVAL0_CYC),
    .CYC1(P_INTERVAL1_CYC),
    .CYC2(P_INTERVAL2_CYC),
    .CYC3(P_INTERVAL3_CYC)
  ) u_ch1_ramp (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_enable(st.regs.ramp_config[bco_pkg::CH1_RAMP_ENABLE_BIT]),
    .i_interval(st.regs.ramp_config[bco_pkg::CH1_RAMP_INTERVAL_LSB +: 2]),
    .o_step(o_ch1_ramp_step)
  );

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // The pin is open drain: only a low is ever driven.
  assign o_sda_out = 1'b0;
  assign o_sda_oe = st.sda_oe;
  assign o_ch4_voltage_code =
    st.regs.ch4_voltage_code[bco_pkg::CH4_CODE_LSB +: bco_pkg::CH4_CODE_W];
  // The adjustable flag is registered and so trails the code by one cycle.
  assign o_ch4_adjustable = st.ch4_adjustable;
  assign o_ch4_ramp_enable = st.regs.ramp_config[bco_pkg::CH4_RAMP_ENABLE_BIT];
  assign o_ch1_ramp_enable = st.regs.ramp_config[bco_pkg::CH1_RAMP_ENABLE_BIT];
  assign o_auto_power_save = st.auto_power_save;
  assign o_discharge_enable = st.regs.option_config[bco_pkg::DISCHARGE_ENABLE_LSB +: 4];

endmodule

// File: tb/bco_option_regs_checker.sv
`timescale 1ns/1ns
module bco_option_regs_checker (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic i_sync_mode,
  input wire logic i_sync_mode_is_clock,
  input wire logic [4:0] i_fuse_ch4_code,
  input wire logic i_fuse_discharge_enable,
  input wire logic [4:0] o_ch4_voltage_code,
  input wire logic o_ch4_adjustable,
  input wire logic o_ch1_ramp_enable,
  input wire logic o_ch4_ramp_enable,
  input wire logic o_ch1_ramp_step,
  input wire logic o_ch4_ramp_step,
  input wire logic [3:0] o_auto_power_save,
  input wire logic [3:0] o_discharge_enable
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  // ---------------------------------------------------------------
  // Sequences
  // ---------------------------------------------------------------
  // Six cycles covers the pin synchroniser plus the output register.
  sequence s_pin_low;
    !i_sync_mode && !i_sync_mode_is_clock;
  endsequence
  sequence s_code_settled;
    $stable(o_ch4_voltage_code) [*2];
  endsequence

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  a_sda_low_only: assert property (o_sda_out == 1'b0)
    else $error("data pin driven high");
  a_oe_rise_low: assert property ($rose(o_sda_oe) |-> !i_scl)
    else $error("data pin taken while clock high");
  a_oe_fall_low: assert property ($fell(o_sda_oe) |-> !i_scl)
    else $error("data pin released while clock high");
  a_adj_follows_code: assert property (s_code_settled |=>
    o_ch4_adjustable == ($past(o_ch4_voltage_code) == 5'h00))
    else $error("adjustable flag does not follow code");
  a_fuse_load: assert property ($rose(i_rst_n) |=>
    o_ch4_voltage_code == i_fuse_ch4_code && o_discharge_enable == {4{i_fuse_discharge_enable}})
    else $error("fuse defaults not loaded");
  a_ramp_reset_off: assert property ($rose(i_rst_n) |=>
    !o_ch1_ramp_enable && !o_ch4_ramp_enable)
    else $error("ramping on after reset");
  a_step1_pulse: assert property (o_ch1_ramp_step |->
    $past(o_ch1_ramp_enable) ##1 !o_ch1_ramp_step)
    else $error("channel 1 step wrong");
  a_step4_pulse: assert property (o_ch4_ramp_step |->
    $past(o_ch4_ramp_enable) ##1 !o_ch4_ramp_step)
    else $error("channel 4 step wrong");
  a_pin_low_auto: assert property (s_pin_low [*6] |=> o_auto_power_save == 4'hF)
    else $error("pin low does not force automatic mode");
endmodule

bind bco_option_regs bco_option_regs_checker u_chk (.*);

// File: tb/bco_host.sv
`timescale 1ns/1ns
module bco_host #(
  parameter logic [6:0] P_ADDR = bco_pkg::DEV_ADDR,
  parameter int H = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  // The clock idles driven high; the data line idles released and the pull-up holds it high.
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic start();
    o_sda_low = 1'b0;
    hold(H);
    o_scl = 1'b1;
    hold(H);
    o_sda_low = 1'b1;
    hold(H);
    o_scl = 1'b0;
    hold(H);
  endtask
  task automatic stop();
    o_sda_low = 1'b1;
    hold(H);
    o_scl = 1'b1;
    hold(H);
    o_sda_low = 1'b0;
    hold(H);
  endtask
  // Data moves two cycles after the clock falls, so the device always sees the fall first.
  task automatic bit_io(input logic b, output logic r);
    o_sda_low = !b;
    hold(H);
    o_scl = 1'b1;
    hold(H);
    r = i_sda;
    o_scl = 1'b0;
    hold(2);
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic get_byte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(last, r);
  endtask
  task automatic wr_reg(input logic [7:0] p, input logic [7:0] d, input logic [7:0] rsv,
                        output logic ok);
    logic a0, a1, a2;
    start();
    put_byte({P_ADDR, 1'b0}, a0);
    put_byte(p, a1);
    put_byte(d & ~rsv, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask
  task automatic rd_reg(input logic [7:0] p, output logic [7:0] d0, output logic [7:0] d1,
                        output logic ok);
    logic a0, a1, a2;
    start();
    put_byte({P_ADDR, 1'b0}, a0);
    put_byte(p, a1);
    start();
    put_byte({P_ADDR, 1'b1}, a2);
    get_byte(1'b0, d0);
    get_byte(1'b1, d1);
    stop();
    ok = a0 & a1 & a2;
  endtask
endmodule

// File: tb/bco_option_regs_tb_top.sv
`timescale 1ns/1ns
module bco_option_regs_tb_top;
  localparam int IV0 = 16;
  localparam int IV1 = 8;
  localparam int IV2 = 4;
  localparam int IV3 = 2;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic mode = 1'b1;
  logic mclk = 1'b0;
  logic fd = 1'b0;
  logic [4:0] fc = 5'h00;
  logic scl, sda_low, sda_w, oe, so, adj, e1, e4, st1, st4, ok;
  logic [4:0] code;
  logic [3:0] aps, dsc;
  logic [7:0] d0, d1;
  logic [4:0] cv [3] = '{5'h00, 5'h1F, 5'h01};
  int iv [4] = '{IV0, IV1, IV2, IV3};
  int n_mismatch = 0;
  int samples_checked = 0;
  int n, i;

  always #4 i_ref_clk = ~i_ref_clk;
  // Open-drain wire with pull-up: low while either party pulls it.
  assign sda_w = (oe ? so : 1'b1) & !sda_low;

  bco_option_regs #(.P_INTERVAL0_CYC(IV0), .P_INTERVAL1_CYC(IV1), .P_INTERVAL2_CYC(IV2),
    .P_INTERVAL3_CYC(IV3)) dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_scl(scl),
    .i_sda(sda_w), .o_sda_out(so), .o_sda_oe(oe), .i_sync_mode(mode),
    .i_sync_mode_is_clock(mclk), .i_fuse_ch4_code(fc), .i_fuse_discharge_enable(fd),
    .o_ch4_voltage_code(code), .o_ch4_adjustable(adj), .o_ch1_ramp_enable(e1),
    .o_ch4_ramp_enable(e4), .o_ch1_ramp_step(st1), .o_ch4_ramp_step(st4),
    .o_auto_power_save(aps), .o_discharge_enable(dsc));
  bco_host host (.i_ref_clk(i_ref_clk), .i_sda(sda_w), .o_scl(scl), .o_sda_low(sda_low));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rst(input logic [4:0] c, input logic f);
    i_rst_n = 1'b0;
    fc = c;
    fd = f;
    host.hold(10);
    i_rst_n = 1'b1;
    host.hold(8);
  endtask
  // Cycles between two steps; zero when no step shows within the bound.
  task automatic per(input logic c4, output int cnt);
    int k;
    k = 0;
    cnt = 0;
    while (k < 100 && (c4 ? st4 : st1) !== 1'b1) begin
      host.hold(1);
      k++;
    end
    if (k < 100) begin
      do begin
        host.hold(1);
        cnt++;
      end while (cnt < 100 && (c4 ? st4 : st1) !== 1'b1);
    end
  endtask
  task automatic complete_run();
    $display("compares %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    for (i = 0; i < 2; i++) begin
      rst(i ? 5'h00 : 5'h13, i == 0);
      host.rd_reg(bco_pkg::ADDR_CH4_VOLTAGE_CODE, d0, d1, ok);
      chk(d0 & 8'h1F, {3'h0, fc});
      chk(d1 & 8'h77, 8'h00);
      chk({7'h0, adj}, {7'h0, fc == 5'h00});
      host.rd_reg(bco_pkg::ADDR_OPTION_CONFIG, d0, d1, ok);
      chk(d0, {{4{fd}}, 4'h0});
      chk({4'h0, dsc}, {4'h0, {4{fd}}});
    end
    for (i = 0; i < 3; i++) begin
      host.wr_reg(bco_pkg::ADDR_CH4_VOLTAGE_CODE, {3'h0, cv[i]}, 8'hE0, ok);
      chk({3'h0, code}, {3'h0, cv[i]});
      chk({7'h0, adj}, {7'h0, cv[i] == 5'h00});
    end
    for (i = 0; i < 4; i++) begin
      host.wr_reg(bco_pkg::ADDR_RAMP_CONFIG, {2'b01, i[1:0], 2'b01, i[1:0]}, 8'h88, ok);
      chk({6'h0, e4, e1}, 8'h03);
      per(1'b0, n);
      chk(n[7:0], iv[i][7:0]);
      per(1'b1, n);
      chk(n[7:0], iv[i][7:0]);
    end
    host.wr_reg(bco_pkg::ADDR_RAMP_CONFIG, 8'h00, 8'h88, ok);
    chk({6'h0, e4, e1}, 8'h00);
    per(1'b0, n);
    chk(n[7:0], 8'h00);
    host.wr_reg(bco_pkg::ADDR_OPTION_CONFIG, 8'h5A, 8'h00, ok);
    chk({4'h0, dsc}, 8'h05);
    for (i = 0; i < 3; i++) begin
      mode = (i == 0);
      mclk = (i == 2);
      host.hold(10);
      chk({4'h0, aps}, {4'h0, (i == 1) ? 4'hF : 4'hA});
    end
    host.rd_reg(bco_pkg::ADDR_OPTION_CONFIG, d0, d1, ok);
    chk(d0, 8'h5A);
    host.start();
    host.put_byte({~bco_pkg::DEV_ADDR, 1'b0}, ok);
    host.stop();
    chk({7'h0, ok}, 8'h00);
    host.wr_reg(8'h10, 8'hA5, 8'h00, ok);
    host.rd_reg(8'h10, d0, d1, ok);
    chk(d0, 8'h00);
    chk({7'h0, ok}, 8'h01);
    complete_run();
  end

  // The full sequence needs some eleven thousand cycles.
  initial begin
    repeat (40000) @(posedge i_ref_clk);
    n_mismatch++;
    complete_run();
  end
endmodule
